// >>> rtl/gcam_pkg.sv
// Constants and types for the graphics coordinate address mapper
// Notes on behaviour
// - Same memory holds twice as many 8-bit rows as 16-bit rows.
// - Work and multi-valued source start addresses hold bits 22..13; lower bits zero.
// - Both display start addresses hold bits 22..16; lower bits zero.
// - Display list start address holds bits 22..5; lower bits zero.
// - Each video area start address holds bits 22..10; lower bits zero.
// - Half-display with 1024-wide memory puts second buffer at X equal 512.
// - One coordinate pair is one pixel; X grows right, Y grows down.
// - Source 2D or linear by attribute; binary linear; work uses work addressing.
// - Screen origin is upper-left; X step one dot, Y step one raster line.
// - Screen X maximum is 1023 or 511 by the memory width bit.
// - Rendering origin is display start, or rendering start when enabled.
// - Depth of rendering and source pixels, 8 or 16 bits, from mode field.
// - Render and work pixels outside the clip area are computed but issue no memory access; source reads are not clipped.
// - Local offsets are added to render and work coordinates; with bold lines sums stay within -2045..2044.
// - System and user clip coordinates are taken without local offset.
// - 2D source origin is its start address; space up to 1024 by 1024.
// - Host 2D image conversion maps virtual coordinates to physical addresses here.
// - Linear source origin, width and height come from polygon command parameters.
// - Binary source is one bit per pixel with a byte-aligned start address.
// - Work coordinates map one to one at one bit, same clip and offset.
package gcam_pkg;
  localparam int ADDR_W     = 23;
  localparam int COORD_W    = 12;
  localparam int SUM_W      = 13;
  localparam int SRC_DIM_W  = 11;
  // Lowest implemented address bit of each start address field
  localparam int WORK_LSB   = 13;
  localparam int MSRC_LSB   = 13;
  localparam int DISP_LSB   = 16;
  localparam int REND_LSB   = 16;
  localparam int DLIST_LSB  = 5;
  localparam int VIDEO_LSB  = 10;
  localparam int ROW_SHIFT_WIDE   = 10;
  localparam int ROW_SHIFT_NARROW = 9;
  localparam logic [ADDR_W-1:0]     HALF_SHIFT_X  = 23'h000200;
  localparam logic [9:0]            SCREEN_X_MAX_WIDE   = 10'h3ff;
  localparam logic [9:0]            SCREEN_X_MAX_NARROW = 10'h1ff;
  localparam logic [SUM_W-1:0]      MSRC_2D_LIMIT = 13'h0400;
  localparam logic signed [SUM_W-1:0] BOLD_MIN  = 13'sh1803;
  localparam logic signed [SUM_W-1:0] BOLD_MAX  = 13'sh07fc;
  localparam logic [2:0]            GBM_16BPP     = 3'h1;
  localparam logic signed [COORD_W-1:0] CLIP_MIN_RESET  = 12'sh000;
  localparam logic signed [COORD_W-1:0] CLIP_XMAX_RESET = 12'sh3ff;
  localparam logic signed [COORD_W-1:0] CLIP_YMAX_RESET = 12'sh7ff;
  localparam logic signed [COORD_W-1:0] OFFSET_RESET    = 12'sh000;

  typedef enum logic [4:0] {
    SP_RENDER   = 5'h01,
    SP_WORK     = 5'h02,
    SP_MSRC     = 5'h04,
    SP_BINSRC   = 5'h08,
    SP_HOSTCONV = 5'h10
  } gcam_space_t;
endpackage

// >>> rtl/gcam_mapper.sv
// Coordinate to graphics memory address mapper with clip and local offset
`timescale 1ns/1ps
module gcam_mapper (
  input  wire logic                           clk_sys,
  input  wire logic                           srst,
  input  wire logic                           memory_width_select,
  input  wire logic [2:0]                     graphic_bit_mode_field,
  input  wire logic                           rendering_start_addr_enable,
  input  wire logic                           half_display_shift,
  input  wire logic                           display_buffer_sel,
  input  wire logic [6:0]                     display_start_reg_first,
  input  wire logic [6:0]                     display_start_reg_second,
  input  wire logic [6:0]                     rendering_start_reg,
  input  wire logic [9:0]                     work_start_reg,
  input  wire logic [9:0]                     multivalued_source_start_addr,
  input  wire logic [17:0]                    display_list_start_addr,
  input  wire logic [12:0]                    video_area_start_addr0,
  input  wire logic [12:0]                    video_area_start_addr1,
  input  wire logic [12:0]                    video_area_start_addr2,
  input  wire logic [1:0]                     video_buf_sel,
  input  wire logic                           local_offset_cmd,
  input  wire logic signed [11:0]             x_offset_value,
  input  wire logic signed [11:0]             y_offset_value,
  input  wire logic                           system_clip_cmd,
  input  wire logic                           user_clip_cmd,
  input  wire logic signed [11:0]             clip_xmin,
  input  wire logic signed [11:0]             clip_ymin,
  input  wire logic signed [11:0]             clip_xmax,
  input  wire logic signed [11:0]             clip_ymax,
  input  wire logic                           req_valid,
  input  wire gcam_pkg::gcam_space_t          req_space,
  input  wire logic signed [11:0]             req_x,
  input  wire logic signed [11:0]             req_y,
  input  wire logic                           req_bold,
  input  wire logic                           source_linear_attr,
  input  wire logic [22:0]                    source_origin_addr,
  input  wire logic [10:0]                    source_width_param,
  input  wire logic [10:0]                    source_height_param,
  output logic                                acc_valid,
  output logic [22:0]                         acc_addr,
  output logic [2:0]                          acc_bit,
  output logic                                acc_wide,
  output logic                                acc_skip,
  output logic                                acc_range_err,
  output logic [22:0]                         display_origin,
  output logic [22:0]                         display_list_base,
  output logic [22:0]                         video_base,
  output logic [9:0]                          screen_x_max
);
  import gcam_pkg::*;

  // ----------------------------------------------------------------
  // Offset and clip state
  // ----------------------------------------------------------------
  logic signed [COORD_W-1:0] x_off_reg, x_off_next, y_off_reg, y_off_next;
  logic signed [COORD_W-1:0] sxmin_reg, sxmin_next, symin_reg, symin_next;
  logic signed [COORD_W-1:0] sxmax_reg, sxmax_next, symax_reg, symax_next;
  logic signed [COORD_W-1:0] uxmin_reg, uxmin_next, uymin_reg, uymin_next;
  logic signed [COORD_W-1:0] uxmax_reg, uxmax_next, uymax_reg, uymax_next;

  always_comb begin
    x_off_next = x_off_reg;
    y_off_next = y_off_reg;
    sxmin_next = sxmin_reg;
    symin_next = symin_reg;
    sxmax_next = sxmax_reg;
    symax_next = symax_reg;
    uxmin_next = uxmin_reg;
    uymin_next = uymin_reg;
    uxmax_next = uxmax_reg;
    uymax_next = uymax_reg;
    if (local_offset_cmd) begin
      x_off_next = x_offset_value;
      y_off_next = y_offset_value;
    end
    // Clip corners are stored raw; the local offset never touches them
    if (system_clip_cmd) begin
      sxmin_next = clip_xmin;
      symin_next = clip_ymin;
      sxmax_next = clip_xmax;
      symax_next = clip_ymax;
    end
    if (user_clip_cmd) begin
      uxmin_next = clip_xmin;
      uymin_next = clip_ymin;
      uxmax_next = clip_xmax;
      uymax_next = clip_ymax;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      x_off_reg <= OFFSET_RESET;
      y_off_reg <= OFFSET_RESET;
      sxmin_reg <= CLIP_MIN_RESET;
      symin_reg <= CLIP_MIN_RESET;
      sxmax_reg <= CLIP_XMAX_RESET;
      symax_reg <= CLIP_YMAX_RESET;
      uxmin_reg <= CLIP_MIN_RESET;
      uymin_reg <= CLIP_MIN_RESET;
      uxmax_reg <= CLIP_XMAX_RESET;
      uymax_reg <= CLIP_YMAX_RESET;
    end else begin
      x_off_reg <= x_off_next;
      y_off_reg <= y_off_next;
      sxmin_reg <= sxmin_next;
      symin_reg <= symin_next;
      sxmax_reg <= sxmax_next;
      symax_reg <= symax_next;
      uxmin_reg <= uxmin_next;
      uymin_reg <= uymin_next;
      uxmax_reg <= uxmax_next;
      uymax_reg <= uymax_next;
    end
  end

  // ----------------------------------------------------------------
  // Origins and modes
  // ----------------------------------------------------------------
  logic                  wide_pix;
  logic [ADDR_W-1:0]     disp_org, rend_org, work_org, msrc_org;
  logic [ADDR_W-1:0]     dlist_org, video_org;
  logic [9:0]            xmax_cur;

  always_comb begin
    wide_pix  = (graphic_bit_mode_field == GBM_16BPP);
    disp_org  = display_buffer_sel ? {display_start_reg_second, {DISP_LSB{1'b0}}}
                                   : {display_start_reg_first, {DISP_LSB{1'b0}}};
    // Second buffer sits 512 pixels to the right in a 1024-wide memory
    if (half_display_shift && memory_width_select && display_buffer_sel) begin
      disp_org = disp_org + (wide_pix ? {HALF_SHIFT_X[ADDR_W-2:0], 1'b0} : HALF_SHIFT_X);
    end
    rend_org  = rendering_start_addr_enable ? {rendering_start_reg, {REND_LSB{1'b0}}}
                                            : disp_org;
    work_org  = {work_start_reg, {WORK_LSB{1'b0}}};
    msrc_org  = {multivalued_source_start_addr, {MSRC_LSB{1'b0}}};
    dlist_org = {display_list_start_addr, {DLIST_LSB{1'b0}}};
    case (video_buf_sel)
      2'h0:    video_org = {video_area_start_addr0, {VIDEO_LSB{1'b0}}};
      2'h1:    video_org = {video_area_start_addr1, {VIDEO_LSB{1'b0}}};
      2'h2:    video_org = {video_area_start_addr2, {VIDEO_LSB{1'b0}}};
      default: video_org = {video_area_start_addr0, {VIDEO_LSB{1'b0}}};
    endcase
    xmax_cur  = memory_width_select ? SCREEN_X_MAX_WIDE : SCREEN_X_MAX_NARROW;
  end

  // ----------------------------------------------------------------
  // Coordinate arithmetic
  // ----------------------------------------------------------------
  // Row-major pixel index: X moves right one pixel, Y one full memory row down
  function automatic logic [ADDR_W-1:0] row_index(input logic [11:0] y,
                                                  input logic [10:0] x,
                                                  input logic        wide_mem);
    logic [ADDR_W-1:0] yrow;
    yrow = wide_mem ? ({11'h000, y} << ROW_SHIFT_WIDE) : ({11'h000, y} << ROW_SHIFT_NARROW);
    return yrow + {12'h000, x};
  endfunction

  logic                  use_off;
  logic signed [SUM_W-1:0] x_sum, y_sum;
  logic signed [COORD_W-1:0] cxmin, cymin, cxmax, cymax;
  logic                  in_clip, in_screen, bold_bad, nonneg, in_src, in_2d;
  logic [ADDR_W-1:0]     rect_idx, lin_idx;

  always_comb begin
    use_off = (req_space == SP_RENDER) || (req_space == SP_WORK);
    x_sum   = $signed({req_x[11], req_x}) + (use_off ? $signed({x_off_reg[11], x_off_reg})
                                                     : 13'sh0000);
    y_sum   = $signed({req_y[11], req_y}) + (use_off ? $signed({y_off_reg[11], y_off_reg})
                                                     : 13'sh0000);
    // Active clip window is the overlap of system and user clip
    cxmin   = (sxmin_reg > uxmin_reg) ? sxmin_reg : uxmin_reg;
    cymin   = (symin_reg > uymin_reg) ? symin_reg : uymin_reg;
    cxmax   = (sxmax_reg < uxmax_reg) ? sxmax_reg : uxmax_reg;
    cymax   = (symax_reg < uymax_reg) ? symax_reg : uymax_reg;
    in_clip = (x_sum >= $signed({cxmin[11], cxmin})) && (x_sum <= $signed({cxmax[11], cxmax}))
           && (y_sum >= $signed({cymin[11], cymin})) && (y_sum <= $signed({cymax[11], cymax}));
    nonneg    = !x_sum[SUM_W-1] && !y_sum[SUM_W-1];
    in_screen = nonneg && (x_sum <= $signed({3'b000, xmax_cur}));
    bold_bad  = req_bold && ((x_sum < BOLD_MIN) || (x_sum > BOLD_MAX)
                          || (y_sum < BOLD_MIN) || (y_sum > BOLD_MAX));
    in_src    = nonneg && (x_sum[10:0] < source_width_param)
                       && ({1'b0, y_sum[10:0]} < {1'b0, source_height_param})
                       && !x_sum[11] && !y_sum[11];
    in_2d     = nonneg && (x_sum < $signed(MSRC_2D_LIMIT))
                       && (y_sum < $signed(MSRC_2D_LIMIT));
    rect_idx  = row_index(y_sum[11:0], x_sum[10:0], memory_width_select);
    lin_idx   = ADDR_W'({12'h000, y_sum[10:0]} * {12'h000, source_width_param})
              + {12'h000, x_sum[10:0]};
  end

  // ----------------------------------------------------------------
  // Access stage
  // ----------------------------------------------------------------
  logic                  acc_valid_reg, acc_valid_next, acc_skip_reg, acc_skip_next;
  logic                  acc_wide_reg, acc_wide_next, acc_err_reg, acc_err_next;
  logic [ADDR_W-1:0]     acc_addr_reg, acc_addr_next;
  logic [2:0]            acc_bit_reg, acc_bit_next;
  logic [ADDR_W-1:0]     disp_reg, dlist_reg, video_reg;
  logic [9:0]            xmax_reg;
  logic                  hit;

  always_comb begin
    hit           = 1'b0;
    acc_addr_next = '0;
    acc_bit_next  = 3'h0;
    acc_wide_next = wide_pix;
    acc_err_next  = 1'b0;
    case (req_space)
      SP_RENDER: begin
        acc_err_next  = bold_bad;
        hit           = in_clip && in_screen && !bold_bad;
        acc_addr_next = rend_org + (wide_pix ? {rect_idx[ADDR_W-2:0], 1'b0} : rect_idx);
      end
      SP_WORK: begin
        // One bit per pixel: byte from the index, bit position from its low bits
        acc_err_next  = bold_bad;
        hit           = in_clip && in_screen && !bold_bad;
        acc_addr_next = work_org + (rect_idx >> 3);
        acc_bit_next  = rect_idx[2:0];
        acc_wide_next = 1'b0;
      end
      SP_MSRC, SP_HOSTCONV: begin
        if (source_linear_attr && (req_space == SP_MSRC)) begin
          hit           = in_src;
          acc_addr_next = source_origin_addr
                        + (wide_pix ? {lin_idx[ADDR_W-2:0], 1'b0} : lin_idx);
        end else begin
          hit           = in_2d;
          acc_addr_next = msrc_org
                        + (wide_pix ? {rect_idx[ADDR_W-2:0], 1'b0} : rect_idx);
        end
      end
      SP_BINSRC: begin
        hit           = in_src;
        acc_addr_next = source_origin_addr + (lin_idx >> 3);
        acc_bit_next  = lin_idx[2:0];
        acc_wide_next = 1'b0;
      end
      default: hit = 1'b0;
    endcase
    acc_valid_next = req_valid && hit;
    acc_skip_next  = req_valid && !hit;
    if (!req_valid) begin
      acc_err_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_valid_reg <= 1'b0;
      acc_skip_reg  <= 1'b0;
      acc_wide_reg  <= 1'b0;
      acc_err_reg   <= 1'b0;
      acc_addr_reg  <= '0;
      acc_bit_reg   <= 3'h0;
      disp_reg      <= '0;
      dlist_reg     <= '0;
      video_reg     <= '0;
      xmax_reg      <= SCREEN_X_MAX_NARROW;
    end else begin
      acc_valid_reg <= acc_valid_next;
      acc_skip_reg  <= acc_skip_next;
      acc_wide_reg  <= acc_wide_next;
      acc_err_reg   <= acc_err_next;
      acc_addr_reg  <= acc_addr_next;
      acc_bit_reg   <= acc_bit_next;
      disp_reg      <= disp_org;
      dlist_reg     <= dlist_org;
      video_reg     <= video_org;
      xmax_reg      <= xmax_cur;
    end
  end

  assign acc_valid         = acc_valid_reg;
  assign acc_skip          = acc_skip_reg;
  assign acc_wide          = acc_wide_reg;
  assign acc_range_err     = acc_err_reg;
  assign acc_addr          = acc_addr_reg;
  assign acc_bit           = acc_bit_reg;
  assign display_origin    = disp_reg;
  assign display_list_base = dlist_reg;
  assign video_base        = video_reg;
  assign screen_x_max      = xmax_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_skip_no_access:
    assert property (req_valid && use_off && !in_clip |=> acc_skip && !acc_valid)
      else $error("clipped pixel issued a memory access");
  a_one_answer:
    assert property (req_valid |=> (acc_valid != acc_skip))
      else $error("request did not give exactly one answer");
  a_no_answer_idle:
    assert property (!req_valid |=> !acc_valid && !acc_skip)
      else $error("answer without request");
  a_dlist_align:
    assert property (!$past(srst)
                     |-> display_list_base == {$past(display_list_start_addr), 5'h00})
      else $error("display list base does not follow its start address");
  a_video_align:
    assert property (!$past(srst) && $past(video_buf_sel) == 2'h3
                     |-> video_base == {$past(video_area_start_addr0), 10'h000})
      else $error("unused video select did not fall back to area zero");
  a_xmax_select:
    assert property (memory_width_select |=> screen_x_max == SCREEN_X_MAX_WIDE)
      else $error("screen X maximum wrong for wide memory");
  a_bold_range:
    assert property (req_valid && use_off && req_bold && (x_sum > BOLD_MAX)
                     |=> acc_range_err && !acc_valid)
      else $error("bold line sum above range not flagged");
  a_half_origin:
    assert property (half_display_shift && memory_width_select && display_buffer_sel
                     && !wide_pix
                     |=> display_origin == {$past(display_start_reg_second), 16'h0200})
      else $error("second buffer not shifted by 512 pixels");
  a_render_origin:
    assert property (req_valid && req_space == SP_RENDER && rendering_start_addr_enable
                     && x_sum == 0 && y_sum == 0 && in_clip
                     |=> acc_valid && acc_addr == {$past(rendering_start_reg), 16'h0000})
      else $error("rendering origin not taken from rendering start");
  a_msrc_limit:
    assert property (req_valid && req_space == SP_MSRC && !source_linear_attr
                     && req_x >= 12'sh400 |=> acc_skip)
      else $error("source coordinate beyond 1023 was accessed");
endmodule

// >>> bench/gcam_mem_model.sv
// Graphics memory stand-in that counts and records the accesses it receives
`timescale 1ns/1ps
module gcam_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        acc_valid,
  input  wire logic [22:0] acc_addr,
  output int               access_count,
  output logic [22:0]      last_addr
);
  // Only issued accesses reach memory; skipped pixels leave no trace here
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      access_count <= 0;
      last_addr    <= 23'h000000;
    end else if (acc_valid === 1'b1) begin
      access_count <= access_count + 1;
      last_addr    <= acc_addr;
    end
  end
endmodule

// >>> bench/tb.sv
// Self-checking bench for the coordinate address mapper
`timescale 1ns/1ps
module tb;
  import gcam_pkg::*;
  logic clk_sys, srst, memory_width_select, rendering_start_addr_enable, half_display_shift;
  logic display_buffer_sel, local_offset_cmd, system_clip_cmd, user_clip_cmd, req_valid;
  logic req_bold, source_linear_attr, acc_valid, acc_wide, acc_skip, acc_range_err;
  logic [2:0] graphic_bit_mode_field, acc_bit;
  logic [6:0] display_start_reg_first, display_start_reg_second, rendering_start_reg;
  logic [9:0] work_start_reg, multivalued_source_start_addr, screen_x_max;
  logic [17:0] display_list_start_addr;
  logic [12:0] video_area_start_addr0, video_area_start_addr1, video_area_start_addr2;
  logic [1:0] video_buf_sel;
  logic signed [11:0] x_offset_value, y_offset_value, clip_xmin, clip_ymin, clip_xmax, clip_ymax;
  logic signed [11:0] req_x, req_y;
  gcam_space_t req_space;
  logic [22:0] source_origin_addr, acc_addr, display_origin, display_list_base, video_base;
  logic [22:0] last_addr;
  logic [10:0] source_width_param, source_height_param;
  int access_count, fails, num_checks, n0;

  gcam_mapper u_gcam_mapper (.*);
  gcam_mem_model u_gcam_mem_model (.clk_sys(clk_sys), .srst(srst), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .access_count(access_count), .last_addr(last_addr));

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // One pixel request; the answer is looked at in the single cycle it stands
  task automatic req(input gcam_space_t sp, input int x, input int y, input logic bold,
                     input logic exp_v);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_space <= sp;
    req_x     <= x[11:0];
    req_y     <= y[11:0];
    req_bold  <= bold;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    chk(acc_valid, exp_v);
    chk(acc_skip, !exp_v);
  endtask

  task automatic set_off(input int xo, input int yo);
    @(posedge clk_sys);
    local_offset_cmd <= 1'b1;
    x_offset_value   <= xo[11:0];
    y_offset_value   <= yo[11:0];
    @(posedge clk_sys);
    local_offset_cmd <= 1'b0;
  endtask

  task automatic set_clip(input int x1, input int y1);
    @(posedge clk_sys);
    system_clip_cmd <= 1'b1;
    user_clip_cmd   <= 1'b1;
    clip_xmin       <= 12'sh000;
    clip_ymin       <= 12'sh000;
    clip_xmax       <= x1[11:0];
    clip_ymax       <= y1[11:0];
    @(posedge clk_sys);
    system_clip_cmd <= 1'b0;
    user_clip_cmd   <= 1'b0;
  endtask

  task automatic t_config;
    logic [12:0] vb [3];
    vb = '{video_area_start_addr0, video_area_start_addr1, video_area_start_addr2};
    chk(screen_x_max, 10'h1ff);
    chk(display_origin, {7'h05, 16'h0000});
    chk(display_list_base, {18'h00123, 5'h00});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      video_buf_sel <= i[1:0];
      settle();
      chk(video_base, {vb[i % 3], 10'h000});
    end
    @(posedge clk_sys);
    display_buffer_sel  <= 1'b1;
    settle();
    chk(display_origin, {7'h06, 16'h0000});
    // Half display needs the shift bit, 1024-wide memory and the second buffer selected
    @(posedge clk_sys);
    memory_width_select <= 1'b1;
    half_display_shift  <= 1'b1;
    display_start_reg_second <= 7'h05;
    settle();
    chk(screen_x_max, 10'h3ff);
    chk(display_origin, {7'h05, 16'h0000} + 23'h000200);
    @(posedge clk_sys);
    graphic_bit_mode_field <= 3'h1;
    settle();
    chk(display_origin, {7'h05, 16'h0000} + 23'h000400);
    @(posedge clk_sys);
    graphic_bit_mode_field <= 3'h0;
    half_display_shift  <= 1'b0;
    display_buffer_sel  <= 1'b0;
    req(SP_RENDER, 0, 1, 1'b0, 1'b1);
    chk(acc_addr, 23'h050400);
    @(posedge clk_sys);
    memory_width_select <= 1'b0;
  endtask

  task automatic t_render;
    req(SP_RENDER, 3, 2, 1'b0, 1'b1);
    chk(acc_addr, 23'h050403);
    chk(acc_wide, 1'b0);
    @(posedge clk_sys);
    graphic_bit_mode_field <= 3'h1;
    req(SP_RENDER, 3, 2, 1'b0, 1'b1);
    chk(acc_addr, 23'h050806);
    chk(acc_wide, 1'b1);
    @(posedge clk_sys);
    graphic_bit_mode_field <= 3'h0;
    rendering_start_addr_enable <= 1'b1;
    req(SP_RENDER, 0, 0, 1'b0, 1'b1);
    chk(acc_addr, 23'h0a0000);
    @(posedge clk_sys);
    rendering_start_addr_enable <= 1'b0;
    req(SP_RENDER, 600, 0, 1'b0, 1'b0);
  endtask

  // Offset moves drawing, but clip limits are taken raw
  task automatic t_offset_clip;
    set_off(5, 1);
    req(SP_RENDER, 0, 0, 1'b0, 1'b1);
    chk(acc_addr, 23'h050205);
    set_clip(10, 10);
    n0 = access_count;
    req(SP_RENDER, 5, 0, 1'b0, 1'b1);
    req(SP_RENDER, 6, 0, 1'b0, 1'b0);
    @(posedge clk_sys);
    #1;
    chk(access_count, n0 + 1);
    chk(last_addr, 23'h05020a);
    set_off(2040, 0);
    req(SP_RENDER, 5, 0, 1'b1, 1'b0);
    chk(acc_range_err, 1'b1);
    req(SP_RENDER, 4, 0, 1'b1, 1'b0);
    chk(acc_range_err, 1'b0);
    set_off(0, 0);
    set_clip(1023, 2047);
  endtask

  task automatic t_sources;
    req(SP_WORK, 13, 1, 1'b0, 1'b1);
    chk(acc_addr, 23'h022041);
    chk(acc_bit, 3'h5);
    req(SP_MSRC, 3, 2, 1'b0, 1'b1);
    chk(acc_addr, 23'h044403);
    req(SP_MSRC, 1024, 0, 1'b0, 1'b0);
    req(SP_HOSTCONV, 3, 2, 1'b0, 1'b1);
    chk(acc_addr, 23'h044403);
    req(SP_BINSRC, 3, 2, 1'b0, 1'b1);
    chk(acc_addr, 23'h012345);
    chk(acc_bit, 3'h3);
    @(posedge clk_sys);
    source_linear_attr <= 1'b1;
    req(SP_MSRC, 3, 2, 1'b0, 1'b1);
    chk(acc_addr, 23'h01236b);
  endtask

  initial begin
    {srst, req_valid} = 2'b10;
    {memory_width_select, rendering_start_addr_enable, half_display_shift} = 3'b000;
    {display_buffer_sel, local_offset_cmd, system_clip_cmd, user_clip_cmd} = 4'h0;
    {req_bold, source_linear_attr, graphic_bit_mode_field, video_buf_sel} = 7'h00;
    display_start_reg_first = 7'h05;
    display_start_reg_second = 7'h06;
    rendering_start_reg = 7'h0a;
    work_start_reg = 10'h011;
    multivalued_source_start_addr = 10'h022;
    display_list_start_addr = 18'h00123;
    video_area_start_addr0 = 13'h0101;
    video_area_start_addr1 = 13'h0202;
    video_area_start_addr2 = 13'h0303;
    {x_offset_value, y_offset_value, req_x, req_y} = 48'h0;
    {clip_xmin, clip_ymin, clip_xmax, clip_ymax} = 48'h0;
    req_space = SP_RENDER;
    source_origin_addr = 23'h012340;
    source_width_param = 11'd20;
    source_height_param = 11'd10;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    settle();
    t_config();
    t_render();
    t_offset_clip();
    t_sources();
    report_and_stop();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
endmodule
